// >>> rcr_pkg.sv
// package: offsets, field positions, defaults and timing for the config register bank
package rcr_pkg;

  // register index values presented through the extended index register
  localparam logic [7:0] IDX_PIN_FUNC  = 8'h16;
  localparam logic [7:0] IDX_LEGACY    = 8'h17;
  localparam logic [7:0] IDX_SHARING   = 8'h18;
  localparam logic [7:0] IDX_FASTCLK   = 8'h19;
  localparam logic [7:0] IDX_FDC_BASE  = 8'h20;
  localparam logic [7:0] IDX_PRT_BASE  = 8'h23;
  localparam logic [7:0] IDX_UA_BASE   = 8'h24;
  localparam logic [7:0] IDX_UB_BASE   = 8'h25;
  localparam logic [7:0] IDX_DMA_ALLOC = 8'h26;
  localparam logic [7:0] IDX_PRT_IRQ   = 8'h27;

  // host i/o ports of the index/data pair, one pair per access select value
  localparam logic [10:0] IDX_PORT_A   = 11'h2E0;
  localparam logic [10:0] IDX_PORT_B   = 11'h160;
  localparam logic [10:0] DATA_PORT_OFS = 11'h001;

  // unlock and exit keys written to the index port
  localparam logic [7:0] KEY_ENTER     = 8'h5A;
  localparam logic [7:0] KEY_EXIT      = 8'hA5;

  // pin function and defaults register fields
  localparam int PIN1_SEL_BIT  = 5;
  localparam int PIN0_SEL_BIT  = 4;
  localparam int PNP_SEL_BIT   = 2;
  localparam int ACCESS_SEL_BIT = 0;

  // legacy gating register fields
  localparam int PRT_DRIVE_BIT = 4;
  localparam int FDC_LGDIS_BIT = 3;
  localparam int PRT_LGDIS_BIT = 2;
  localparam int UA_LGDIS_BIT  = 1;
  localparam int UB_LGDIS_BIT  = 0;

  // fast clock register fields
  localparam int UA_FAST_BIT   = 1;
  localparam int UB_FAST_BIT   = 0;

  // writable bit masks, reserved bits stay zero
  localparam logic [7:0] MASK_PIN_FUNC = 8'h35;
  localparam logic [7:0] MASK_LEGACY   = 8'h1F;
  localparam logic [7:0] MASK_SHARING  = 8'hFF;
  localparam logic [7:0] MASK_FASTCLK  = 8'h03;
  localparam logic [7:0] MASK_FDC_BASE = 8'hFC;
  localparam logic [7:0] MASK_PRT_BASE = 8'hFF;
  localparam logic [7:0] MASK_UART_BASE = 8'hFE;
  localparam logic [7:0] MASK_DMA_ALLOC = 8'hFF;
  localparam logic [7:0] MASK_PRT_IRQ  = 8'hEF;

  // reset and plug-and-play default values
  localparam logic [7:0] RST_VALUE     = 8'h00;
  localparam logic [7:0] DEF_FDC_BASE  = 8'hFC;
  localparam logic [7:0] DEF_PRT_BASE  = 8'hDE;
  localparam logic [7:0] DEF_UA_BASE   = 8'hFE;
  localparam logic [7:0] DEF_UB_BASE   = 8'hBE;
  localparam logic [7:0] DEF_DMA_ALLOC = 8'h23;
  localparam logic [7:0] DEF_PRT_IRQ   = 8'h05;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int IRQ_PULSE_NS  = 200;
  localparam logic [4:0] IRQ_PULSE_CYC =
    5'((IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] STRAP_WAIT_CYC = 2'h2;

endpackage

// >>> rcr_config_bank.sv
// module: configuration register bank with host index/data access and resource routing
//
// Behaviour
// RQ1: bit 4 zero makes shared pin interrupt B, one makes it general I/O zero.
// RQ2: default select zero clears base, DMA and IRQ registers; one loads defaults.
// RQ3: defaults are FC, DE, FE, BE, 23 and 05 for the allocation registers.
// RQ4: default select write reloads only when the new value differs from old.
// RQ5: access select plus external enable choose the unlock sequence and ports.
// RQ6: strap pins set shared-pin, default and access select bits after power-on.
// RQ7: printer IRQ open-drain only in ECP/EPP when drive bit zero.
// RQ8: floppy legacy disable zero lets output register bit 3 gate IRQ/DRQ.
// RQ9: printer legacy disable zero lets control bit 4 gate IRQ/DRQ.
// RQ10: UART legacy disable zero lets modem control bit 3 gate UART IRQ.
// RQ11: sharing pin pulses low 200ns per request, tri-stated otherwise.
// RQ12: sharing register bit n selects sharing mode for pin n, A to H.
// RQ13: fast clock bit picks the 14.769MHz UART clock, else normal selection.
// RQ14: floppy base 7..2 matches A9..4, A3 low, chip select and A10 low.
// RQ15: base bits 7 and 6 both zero disable that function's decode.
// RQ16: parallel base matches A9..2, or eight-byte windows with EPP on.
// RQ17: parallel needs A10 low except ECP, where A10 picks extended registers.
// RQ18: UART base 7..1 matches A9..3, chip select and A10 low.
// RQ19: reserved low bits of floppy and UART base registers read zero.
// RQ20: DMA upper nibble floppy, lower printer; 0 none, 1..3 channels A..C.
// RQ21: index register picks which register the data port reads and writes.
// RQ22: DMA codes above three select no channel at all.
// RQ23: bit 5 zero makes second shared pin interrupt A, one general I/O one.

`timescale 1ns/1ps
`default_nettype none

module rcr_config_bank (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // host i/o bus pins
  input  wire logic [10:0] host_addr,
  input  wire logic        host_aen,
  input  wire logic        chip_select_n,
  input  wire logic        host_iow_n,
  input  wire logic        host_ior_n,
  input  wire logic [7:0]  host_data_in,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe,
  // power-on strap pins
  input  wire logic        uart_b_rts_strap,
  input  wire logic        uart_a_rts_strap,
  input  wire logic        uart_a_dtr_strap,
  // control from neighbouring logic
  input  wire logic        ext_access_enable,
  input  wire logic        printer_mode_ecp_epp,
  input  wire logic        printer_mode_ecp,
  input  wire logic        printer_epp_enable,
  // function block requests and legacy gate bits
  input  wire logic        floppy_irq,
  input  wire logic        floppy_drq,
  input  wire logic        floppy_dor_bit3,
  input  wire logic        printer_irq,
  input  wire logic        printer_drq,
  input  wire logic        printer_device_control_bit4,
  input  wire logic        serial_a_irq,
  input  wire logic        serial_a_modem_control_bit3,
  input  wire logic        serial_b_irq,
  input  wire logic        serial_b_modem_control_bit3,
  // routed interrupt requests and pin usage per pin A..H
  input  wire logic [7:0]  irq_pin_req,
  input  wire logic [7:0]  irq_pin_used,
  // dma acknowledge pins, channels A..C
  input  wire logic [2:0]  dma_ack,
  // interrupt pins A..H
  output logic      [7:0]  irq_pin_out,
  output logic      [7:0]  irq_pin_oe,
  // dma request pins and acknowledges back to functions
  output logic      [2:0]  dma_req,
  output logic             floppy_dack,
  output logic             printer_dack,
  // gated interrupts and drive type
  output logic             floppy_irq_gated,
  output logic             printer_irq_gated,
  output logic             serial_a_irq_gated,
  output logic             serial_b_irq_gated,
  output logic             printer_irq_open_drain,
  // uart clock selection
  output logic             serial_a_fast_clock,
  output logic             serial_b_fast_clock,
  // shared pin function
  output logic             shared_pin0_select,
  output logic             shared_pin1_select,
  // address decode selects
  output logic             floppy_select,
  output logic             parallel_select,
  output logic             parallel_ext_select,
  output logic             serial_a_select,
  output logic             serial_b_select
);

  typedef struct packed {
    logic [10:0]     addr_s1;
    logic [10:0]     addr_s2;
    logic            aen_s1;
    logic            aen_s2;
    logic            csn_s1;
    logic            csn_s2;
    logic            iow_s1;
    logic            iow_s2;
    logic            iow_d;
    logic            ior_s1;
    logic            ior_s2;
    logic [7:0]      data_s1;
    logic [7:0]      data_s2;
    logic [2:0]      dack_s1;
    logic [2:0]      dack_s2;
    logic [2:0]      strap_s1;
    logic [2:0]      strap_s2;
    logic [1:0]      strap_cnt;
    logic            strap_done;
    logic            ext_mode;
    logic            key_seen;
    logic [7:0]      index;
    logic [7:0]      pin_func;
    logic [7:0]      legacy;
    logic [7:0]      sharing;
    logic [7:0]      fastclk;
    logic [7:0]      fdc_base;
    logic [7:0]      prt_base;
    logic [7:0]      ua_base;
    logic [7:0]      ub_base;
    logic [7:0]      dma_alloc;
    logic [7:0]      prt_irq;
    logic [7:0]      rd_data;
    logic            rd_oe;
    logic [7:0]      req_d;
    logic [7:0][4:0] pulse_cnt;
    logic [7:0]      pin_out;
    logic [7:0]      pin_oe;
    logic [2:0]      dreq;
    logic            fd_dack;
    logic            pp_dack;
    logic            fd_irq;
    logic            pp_irq;
    logic            ua_irq;
    logic            ub_irq;
    logic            pp_od;
    logic            ua_fast;
    logic            ub_fast;
    logic            pin0_sel;
    logic            pin1_sel;
    logic            fd_sel;
    logic            pp_sel;
    logic            pp_ext;
    logic            ua_sel;
    logic            ub_sel;
  } rcr_state_type;

  rcr_state_type st_ff;
  rcr_state_type nxt_st;

  // a base register with bits 7 and 6 clear turns its decode off
  function automatic logic base_on(input logic [7:0] base);
    base_on = base[7] | base[6]; // [RQ15]
  endfunction

  // one-hot channel from an allocation nibble; unknown codes select nothing
  function automatic logic [2:0] dma_onehot(input logic [3:0] code);
    case (code)
      4'h1:    dma_onehot = 3'h1; // [RQ20]
      4'h2:    dma_onehot = 3'h2; // [RQ20]
      4'h3:    dma_onehot = 3'h4; // [RQ20]
      default: dma_onehot = 3'h0; // [RQ22]
    endcase
  endfunction

  // plug-and-play allocation registers take defaults or zeros
  function automatic rcr_state_type pnp_load(input rcr_state_type s, input logic def);
    rcr_state_type r;
    r = s;
    r.fdc_base  = def ? rcr_pkg::DEF_FDC_BASE  : rcr_pkg::RST_VALUE; // [RQ2] [RQ3]
    r.prt_base  = def ? rcr_pkg::DEF_PRT_BASE  : rcr_pkg::RST_VALUE; // [RQ2] [RQ3]
    r.ua_base   = def ? rcr_pkg::DEF_UA_BASE   : rcr_pkg::RST_VALUE; // [RQ2] [RQ3]
    r.ub_base   = def ? rcr_pkg::DEF_UB_BASE   : rcr_pkg::RST_VALUE; // [RQ2] [RQ3]
    r.dma_alloc = def ? rcr_pkg::DEF_DMA_ALLOC : rcr_pkg::RST_VALUE; // [RQ2] [RQ3]
    r.prt_irq   = def ? rcr_pkg::DEF_PRT_IRQ   : rcr_pkg::RST_VALUE; // [RQ2] [RQ3]
    return r;
  endfunction

  always_comb begin
    rcr_state_type n;
    logic [10:0]   idx_port;
    logic [10:0]   dat_port;
    logic          wr_edge;
    logic          wr_idx;
    logic          wr_dat;
    logic          io_ok;
    logic [7:0]    wval;
    logic [7:0]    rsel;
    logic          fd_drq_g;
    logic          pp_drq_g;
    logic [2:0]    fd_ch;
    logic [2:0]    pp_ch;
    logic          rise;
    n = st_ff;
    rsel = 8'h00;
    rise = 1'b0;
    wval = st_ff.data_s2;
    // index and data ports move with the access select bit
    idx_port = st_ff.pin_func[rcr_pkg::ACCESS_SEL_BIT] ?
               rcr_pkg::IDX_PORT_B : rcr_pkg::IDX_PORT_A; // [RQ5]
    dat_port = 11'(idx_port + rcr_pkg::DATA_PORT_OFS);
    io_ok    = st_ff.strap_done & ~st_ff.aen_s2;
    wr_edge  = io_ok & st_ff.iow_d & ~st_ff.iow_s2;
    wr_idx   = wr_edge & (st_ff.addr_s2 == idx_port);
    wr_dat   = wr_edge & (st_ff.addr_s2 == dat_port) & st_ff.ext_mode;
    fd_drq_g = floppy_drq & (st_ff.legacy[rcr_pkg::FDC_LGDIS_BIT] | floppy_dor_bit3); // [RQ8]
    pp_drq_g = printer_drq &
               (st_ff.legacy[rcr_pkg::PRT_LGDIS_BIT] | printer_device_control_bit4); // [RQ9]
    fd_ch      = dma_onehot(st_ff.dma_alloc[7:4]); // [RQ20]
    pp_ch      = dma_onehot(st_ff.dma_alloc[3:0]); // [RQ20]

    // pin synchronisers
    n.addr_s1  = host_addr;
    n.addr_s2  = st_ff.addr_s1;
    n.aen_s1   = host_aen;
    n.aen_s2   = st_ff.aen_s1;
    n.csn_s1   = chip_select_n;
    n.csn_s2   = st_ff.csn_s1;
    n.iow_s1   = host_iow_n;
    n.iow_s2   = st_ff.iow_s1;
    n.iow_d    = st_ff.iow_s2;
    n.ior_s1   = host_ior_n;
    n.ior_s2   = st_ff.ior_s1;
    n.data_s1  = host_data_in;
    n.data_s2  = st_ff.data_s1;
    n.dack_s1  = dma_ack;
    n.dack_s2  = st_ff.dack_s1;
    n.strap_s1 = {uart_b_rts_strap, uart_a_rts_strap, uart_a_dtr_strap};
    n.strap_s2 = st_ff.strap_s1;

    // strap capture waits until the synchronisers hold pin levels
    if (!st_ff.strap_done) begin
      if (st_ff.strap_cnt == rcr_pkg::STRAP_WAIT_CYC) begin
        n.strap_done = 1'b1;
        n.pin_func = 8'h00;
        n.pin_func[rcr_pkg::PIN1_SEL_BIT]   = st_ff.strap_s2[2]; // [RQ6]
        n.pin_func[rcr_pkg::PIN0_SEL_BIT]   = st_ff.strap_s2[2]; // [RQ6]
        n.pin_func[rcr_pkg::PNP_SEL_BIT]    = st_ff.strap_s2[1]; // [RQ6]
        n.pin_func[rcr_pkg::ACCESS_SEL_BIT] = st_ff.strap_s2[0]; // [RQ6]
        n = pnp_load(n, st_ff.strap_s2[1]); // [RQ2]
      end else begin
        n.strap_cnt = 2'(st_ff.strap_cnt + 2'h1);
      end
    end

    // unlock: one key write, or two in a row when the external enable is set
    if (wr_idx && !st_ff.ext_mode) begin
      if (st_ff.data_s2 == rcr_pkg::KEY_ENTER) begin
        if (!ext_access_enable || st_ff.key_seen) begin // [RQ5]
          n.ext_mode = 1'b1;
          n.key_seen = 1'b0;
        end else begin
          n.key_seen = 1'b1;
        end
      end else begin
        n.key_seen = 1'b0;
      end
    end else if (wr_idx) begin
      if (st_ff.data_s2 == rcr_pkg::KEY_EXIT) begin
        n.ext_mode = 1'b0;
      end else begin
        n.index = st_ff.data_s2; // [RQ21]
      end
    end

    // data port writes land in the indexed register, reserved bits masked
    if (wr_dat) begin
      case (st_ff.index) // [RQ21]
        rcr_pkg::IDX_PIN_FUNC: begin
          n.pin_func = wval & rcr_pkg::MASK_PIN_FUNC;
          // an unchanged default select leaves the allocation registers alone
          if (wval[rcr_pkg::PNP_SEL_BIT] != st_ff.pin_func[rcr_pkg::PNP_SEL_BIT]) begin // [RQ4]
            n = pnp_load(n, wval[rcr_pkg::PNP_SEL_BIT]); // [RQ2]
          end
        end
        rcr_pkg::IDX_LEGACY:    n.legacy    = wval & rcr_pkg::MASK_LEGACY;
        rcr_pkg::IDX_SHARING:   n.sharing   = wval & rcr_pkg::MASK_SHARING;
        rcr_pkg::IDX_FASTCLK:   n.fastclk   = wval & rcr_pkg::MASK_FASTCLK;
        rcr_pkg::IDX_FDC_BASE:  n.fdc_base  = wval & rcr_pkg::MASK_FDC_BASE; // [RQ19]
        rcr_pkg::IDX_PRT_BASE:  n.prt_base  = wval & rcr_pkg::MASK_PRT_BASE;
        rcr_pkg::IDX_UA_BASE:   n.ua_base   = wval & rcr_pkg::MASK_UART_BASE; // [RQ19]
        rcr_pkg::IDX_UB_BASE:   n.ub_base   = wval & rcr_pkg::MASK_UART_BASE; // [RQ19]
        rcr_pkg::IDX_DMA_ALLOC: n.dma_alloc = wval & rcr_pkg::MASK_DMA_ALLOC;
        rcr_pkg::IDX_PRT_IRQ:   n.prt_irq   = wval & rcr_pkg::MASK_PRT_IRQ;
        default: ;
      endcase
    end

    // read mux; unmapped indices read zero
    case (st_ff.index) // [RQ21]
      rcr_pkg::IDX_PIN_FUNC:  rsel = st_ff.pin_func;
      rcr_pkg::IDX_LEGACY:    rsel = st_ff.legacy;
      rcr_pkg::IDX_SHARING:   rsel = st_ff.sharing;
      rcr_pkg::IDX_FASTCLK:   rsel = st_ff.fastclk;
      rcr_pkg::IDX_FDC_BASE:  rsel = st_ff.fdc_base;
      rcr_pkg::IDX_PRT_BASE:  rsel = st_ff.prt_base;
      rcr_pkg::IDX_UA_BASE:   rsel = st_ff.ua_base;
      rcr_pkg::IDX_UB_BASE:   rsel = st_ff.ub_base;
      rcr_pkg::IDX_DMA_ALLOC: rsel = st_ff.dma_alloc;
      rcr_pkg::IDX_PRT_IRQ:   rsel = st_ff.prt_irq;
      default:                rsel = 8'h00;
    endcase
    n.rd_oe   = io_ok & st_ff.ext_mode & ~st_ff.ior_s2 &
                ((st_ff.addr_s2 == idx_port) | (st_ff.addr_s2 == dat_port));
    n.rd_data = (st_ff.addr_s2 == idx_port) ? st_ff.index : rsel;

    // function decode from the synchronised address
    n.fd_sel = io_ok & ~st_ff.csn_s2 & ~st_ff.addr_s2[10] & base_on(st_ff.fdc_base) &
               (st_ff.addr_s2[9:4] == st_ff.fdc_base[7:2]) & ~st_ff.addr_s2[3]; // [RQ14]
    n.pp_sel = io_ok & ~st_ff.csn_s2 & base_on(st_ff.prt_base) &
               (printer_mode_ecp | ~st_ff.addr_s2[10]) & // [RQ17]
               (printer_epp_enable ? (st_ff.addr_s2[9:3] == st_ff.prt_base[7:1]) :
                                     (st_ff.addr_s2[9:2] == st_ff.prt_base)); // [RQ16]
    n.pp_ext = n.pp_sel & printer_mode_ecp & st_ff.addr_s2[10]; // [RQ17]
    n.ua_sel = io_ok & ~st_ff.csn_s2 & ~st_ff.addr_s2[10] & base_on(st_ff.ua_base) &
               (st_ff.addr_s2[9:3] == st_ff.ua_base[7:1]); // [RQ18]
    n.ub_sel = io_ok & ~st_ff.csn_s2 & ~st_ff.addr_s2[10] & base_on(st_ff.ub_base) &
               (st_ff.addr_s2[9:3] == st_ff.ub_base[7:1]); // [RQ18]

    // legacy gating of requests
    n.fd_irq = floppy_irq & (st_ff.legacy[rcr_pkg::FDC_LGDIS_BIT] | floppy_dor_bit3); // [RQ8]
    n.pp_irq = printer_irq &
               (st_ff.legacy[rcr_pkg::PRT_LGDIS_BIT] | printer_device_control_bit4); // [RQ9]
    n.ua_irq = serial_a_irq &
               (st_ff.legacy[rcr_pkg::UA_LGDIS_BIT] | serial_a_modem_control_bit3); // [RQ10]
    n.ub_irq = serial_b_irq &
               (st_ff.legacy[rcr_pkg::UB_LGDIS_BIT] | serial_b_modem_control_bit3); // [RQ10]
    n.pp_od  = ~st_ff.legacy[rcr_pkg::PRT_DRIVE_BIT] & printer_mode_ecp_epp; // [RQ7]

    // dma routing; two functions on one channel simply irq_pin_e_sharing it
    n.dreq     = (fd_ch & {3{fd_drq_g}}) | (pp_ch & {3{pp_drq_g}}); // [RQ22]
    n.fd_dack  = |(fd_ch & st_ff.dack_s2);
    n.pp_dack  = |(pp_ch & st_ff.dack_s2);

    // clock and pin function selects
    n.ua_fast  = st_ff.fastclk[rcr_pkg::UA_FAST_BIT]; // [RQ13]
    n.ub_fast  = st_ff.fastclk[rcr_pkg::UB_FAST_BIT]; // [RQ13]
    n.pin0_sel = st_ff.pin_func[rcr_pkg::PIN0_SEL_BIT]; // [RQ1]
    n.pin1_sel = st_ff.pin_func[rcr_pkg::PIN1_SEL_BIT]; // [RQ23]

    // interrupt pins: legacy follows the request, sharing pulses low per rising edge
    n.req_d = irq_pin_req;
    for (int i = 0; i < 8; i++) begin
      rise = irq_pin_req[i] & ~st_ff.req_d[i];
      if (st_ff.sharing[i]) begin // [RQ12]
        if (st_ff.pulse_cnt[i] != 5'h00) begin
          n.pulse_cnt[i] = 5'(st_ff.pulse_cnt[i] - 5'h01);
        end else if (rise) begin
          n.pulse_cnt[i] = rcr_pkg::IRQ_PULSE_CYC; // [RQ11]
        end
        n.pin_out[i] = 1'b0; // [RQ11]
        n.pin_oe[i]  = (n.pulse_cnt[i] != 5'h00); // [RQ11]
      end else begin
        // a request arriving mid-pulse is dropped; legacy mode clears the count
        n.pulse_cnt[i] = 5'h00;
        n.pin_out[i]   = irq_pin_req[i];
        n.pin_oe[i]    = irq_pin_used[i];
      end
    end

    nxt_st = n;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.iow_s1 <= 1'b1;
      st_ff.iow_s2 <= 1'b1;
      st_ff.iow_d  <= 1'b1;
      st_ff.ior_s1 <= 1'b1;
      st_ff.ior_s2 <= 1'b1;
      st_ff.csn_s1 <= 1'b1;
      st_ff.csn_s2 <= 1'b1;
      st_ff.aen_s1 <= 1'b1;
      st_ff.aen_s2 <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign host_data_out          = st_ff.rd_data;
  assign host_data_oe           = st_ff.rd_oe;
  assign irq_pin_out            = st_ff.pin_out;
  assign irq_pin_oe             = st_ff.pin_oe;
  assign dma_req                = st_ff.dreq;
  assign floppy_dack            = st_ff.fd_dack;
  assign printer_dack           = st_ff.pp_dack;
  assign floppy_irq_gated       = st_ff.fd_irq;
  assign printer_irq_gated      = st_ff.pp_irq;
  assign serial_a_irq_gated     = st_ff.ua_irq;
  assign serial_b_irq_gated     = st_ff.ub_irq;
  assign printer_irq_open_drain = st_ff.pp_od;
  assign serial_a_fast_clock    = st_ff.ua_fast;
  assign serial_b_fast_clock    = st_ff.ub_fast;
  assign shared_pin0_select     = st_ff.pin0_sel;
  assign shared_pin1_select     = st_ff.pin1_sel;
  assign floppy_select          = st_ff.fd_sel;
  assign parallel_select        = st_ff.pp_sel;
  assign parallel_ext_select    = st_ff.pp_ext;
  assign serial_a_select        = st_ff.ua_sel;
  assign serial_b_select        = st_ff.ub_sel;

endmodule

`default_nettype wire

// >>> rcr_chk.sv
// checker: port-level assertions for the configuration register bank
`timescale 1ns/1ps
`default_nettype none

module rcr_chk (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // host bus
  input  wire logic [10:0] host_addr,
  input  wire logic        host_aen,
  input  wire logic        chip_select_n,
  input  wire logic        host_ior_n,
  input  wire logic        host_data_oe,
  // requests and gated results
  input  wire logic        floppy_irq,
  input  wire logic        floppy_irq_gated,
  input  wire logic        serial_a_irq,
  input  wire logic        serial_a_irq_gated,
  input  wire logic        floppy_drq,
  input  wire logic        printer_drq,
  input  wire logic [2:0]  dma_req,
  input  wire logic [7:0]  irq_pin_oe,
  input  wire logic [7:0]  irq_pin_out,
  // decode selects
  input  wire logic        floppy_select,
  input  wire logic        serial_a_select,
  input  wire logic        parallel_ext_select
);
  logic [5:0] run_cnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // counts the low-drive run on pin a; the bench keeps legacy enables off
  always_ff @(posedge ref_clk) begin
    if (sys_rst) run_cnt <= 6'h00;
    else run_cnt <= (irq_pin_oe[0] && !irq_pin_out[0]) ? 6'(run_cnt + 6'h01) : 6'h00;
  end

  a_irq_pin_e_sharing_pulse_len: assert property ($fell(irq_pin_oe[0]) |-> run_cnt == 6'h14)
    else $error("sharing pulse length wrong");
  a_floppy_decode: assert property (floppy_select |->
    $past(!host_addr[3] && !host_addr[10] && !chip_select_n && !host_aen, 3))
    else $error("floppy select without valid address");
  a_serial_decode: assert property (serial_a_select |->
    $past(!host_addr[10] && !chip_select_n, 3))
    else $error("serial a select without valid address");
  a_par_ext_a10: assert property (parallel_ext_select |-> $past(host_addr[10], 3))
    else $error("extended select without a10");
  a_read_drive: assert property (host_data_oe |-> $past(!host_ior_n && !host_aen, 3))
    else $error("data bus driven without read");
  a_floppy_gate: assert property (floppy_irq_gated |-> $past(floppy_irq))
    else $error("floppy irq without request");
  a_serial_gate: assert property (serial_a_irq_gated |-> $past(serial_a_irq))
    else $error("serial a irq without request");
  a_dma_cause: assert property (|dma_req |-> $past(floppy_drq || printer_drq))
    else $error("dma request without cause");
endmodule

bind rcr_config_bank rcr_chk chk (.*);

`default_nettype wire

// >>> rcr_host.sv
// host model: isa i/o cycles through the index/data pair
`timescale 1ns/1ps
`default_nettype none

module rcr_host (
  // clock
  input  wire logic        ref_clk,
  // isa bus
  output logic      [10:0] host_addr,
  output logic             host_aen,
  output logic             chip_select_n,
  output logic             host_iow_n,
  output logic             host_ior_n,
  output logic      [7:0]  host_data_in,
  input  wire logic [7:0]  host_data_out
);
  initial begin
    host_addr = 11'h000;
    host_aen = 1'b0;
    chip_select_n = 1'b0;
    host_iow_n = 1'b1;
    host_ior_n = 1'b1;
    host_data_in = 8'h00;
  end

  task automatic put(input logic [10:0] a);
    @(posedge ref_clk);
    host_addr <= a;
    repeat (5) @(posedge ref_clk);
  endtask

  // address and data held past the strobe, the pin synchronisers need it
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_data_in <= d;
    repeat (2) @(posedge ref_clk);
    host_iow_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    host_iow_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host_data_in <= ~d;
  endtask

  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    repeat (2) @(posedge ref_clk);
    host_ior_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    d = host_data_out;
    host_ior_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic unlock();
    wr(rcr_pkg::IDX_PORT_A, rcr_pkg::KEY_ENTER);
  endtask

  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] v);
    wr(rcr_pkg::IDX_PORT_A, i);
    wr(rcr_pkg::IDX_PORT_A + rcr_pkg::DATA_PORT_OFS, v);
  endtask

  task automatic cfg_rd(input logic [7:0] i, output logic [7:0] v);
    wr(rcr_pkg::IDX_PORT_A, i);
    rd(rcr_pkg::IDX_PORT_A + rcr_pkg::DATA_PORT_OFS, v);
  endtask
endmodule

`default_nettype wire

// >>> rcr_config_bank_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none

module rcr_config_bank_tb;
  logic ref_clk = 1'b0, sys_rst = 1'b1;
  logic [10:0] host_addr;
  logic [7:0] host_data_in, host_data_out, irq_pin_out, irq_pin_oe;
  logic host_aen, chip_select_n, host_iow_n, host_ior_n, host_data_oe;
  logic uart_b_rts_strap = 1'b0, uart_a_rts_strap = 1'b1, uart_a_dtr_strap = 1'b0;
  logic ext_access_enable = 1'b0, printer_mode_ecp_epp = 1'b1, printer_mode_ecp = 1'b0;
  logic printer_epp_enable = 1'b0, floppy_irq = 1'b0, floppy_drq = 1'b0;
  logic floppy_dor_bit3 = 1'b0, printer_irq = 1'b1, printer_drq = 1'b0;
  logic printer_device_control_bit4 = 1'b0, serial_a_irq = 1'b0, serial_b_irq = 1'b0;
  logic serial_a_modem_control_bit3 = 1'b0, serial_b_modem_control_bit3 = 1'b0;
  logic [7:0] irq_pin_req = 8'h00, irq_pin_used = 8'h00;
  logic [2:0] dma_ack = 3'h0, dma_req;
  logic floppy_dack, printer_dack, floppy_irq_gated, printer_irq_gated;
  logic serial_a_irq_gated, serial_b_irq_gated, printer_irq_open_drain;
  logic serial_a_fast_clock, serial_b_fast_clock, shared_pin0_select, shared_pin1_select;
  logic floppy_select, parallel_select, parallel_ext_select, serial_a_select, serial_b_select;
  int n_errors = 0, samples_checked = 0, cycles = 0;

  rcr_config_bank dut (.*);
  rcr_host host (.*);

  initial forever #5 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ceiling: the run needs under two thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] v;
    host.cfg_rd(i, v);
    chk(v, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic dec(input logic [10:0] a, input logic [7:0] e);
    host.put(a);
    #1;
    chk({5'h0, floppy_select, parallel_select, serial_a_select}, e);
  endtask

  task automatic t_pnp();
    rchk(8'h16, 8'h04);
    rchk(8'h17, 8'h00);
    rchk(8'h30, 8'h00);
    host.cfg_wr(8'h20, 8'h40);
    host.cfg_wr(8'h16, 8'h04);
    rchk(8'h20, 8'h40);
    host.cfg_wr(8'h16, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h26, 8'h00);
    host.cfg_wr(8'h16, 8'h04);
    rchk(8'h20, 8'hFC);
    rchk(8'h23, 8'hDE);
    rchk(8'h24, 8'hFE);
    rchk(8'h25, 8'hBE);
    rchk(8'h26, 8'h23);
    rchk(8'h27, 8'h05);
    host.cfg_wr(8'h20, 8'hFF);
    rchk(8'h20, 8'hFC);
    host.cfg_wr(8'h25, 8'hFF);
    rchk(8'h25, 8'hFE);
  endtask

  task automatic t_decode();
    dec(11'h3F0, 8'h04);
    dec(11'h3F8, 8'h01);
    dec(11'h7F8, 8'h00);
    dec(11'h378, 8'h02);
    dec(11'h37C, 8'h00);
    host.cfg_wr(8'h24, 8'h00);
    dec(11'h3F8, 8'h00);
  endtask

  task automatic t_gates();
    host.cfg_wr(8'h19, 8'h02);
    floppy_irq <= 1'b1;
    serial_a_irq <= 1'b1;
    settle(3);
    chk({6'h0, floppy_irq_gated, serial_a_irq_gated}, 8'h00);
    host.cfg_wr(8'h17, 8'h1E);
    host.cfg_wr(8'h16, 8'h34);
    settle(2);
    chk({6'h0, floppy_irq_gated, serial_a_irq_gated}, 8'h03);
    chk({2'h0, serial_a_fast_clock, serial_b_fast_clock, shared_pin1_select, shared_pin0_select,
         printer_irq_open_drain, printer_irq_gated}, 8'h2D);
  endtask

  task automatic t_irq_pin_e_sharing();
    int n = 0;
    int m = 0;
    host.cfg_wr(8'h18, 8'h01);
    irq_pin_req <= 8'h03;
    repeat (40) begin
      settle(1);
      if (irq_pin_oe[0] === 1'b1 && irq_pin_out[0] === 1'b0) n++;
      if (irq_pin_oe[1] !== 1'b0) m++;
    end
    @(posedge ref_clk) irq_pin_req <= 8'h00;
    chk(8'(n), 8'h14);
    chk(8'(m), 8'h00);
  endtask

  task automatic t_dma();
    floppy_drq <= 1'b1;
    dma_ack <= 3'b010;
    settle(5);
    chk({4'h0, floppy_dack, dma_req}, 8'h0A);
    host.cfg_wr(8'h26, 8'h43);
    settle(4);
    chk({4'h0, floppy_dack, dma_req}, 8'h00);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle(10);
    host.unlock();
    t_pnp();
    t_decode();
    t_gates();
    t_irq_pin_e_sharing();
    t_dma();
    report_and_stop();
  end
endmodule

`default_nettype wire
